// >>> src/id_link_master.sv
// Bus master that reads the 64-bit identification word over one wire
// Summary of operation
// R1: Device word: family, 48-bit serial, check
// R2: Bits travel least significant first
// R3: Every slot starts with master falling edge
// R4: Only pull low or release, never high
// R5: Pauses leave the line released high
// R6: Low over 120 us resets devices
// R7: Order: reset, command byte, then data
// R8: Reset pulse answered by presence pulse
// R9: Exactly one eight-bit command after presence
// R10: 33h or 0Fh returns whole word
// R11: Read command only with single slave
// R12: 55h or CCh silences device until reset
// R13: Ignoring device never pulls the line
// R14: Slots no faster than 16.3 kbit/s
// R15: Reset 480 us; presence after 15-60 us
// R16: Write sampled after delay; read zero held
// R17: Search: bit, complement, then chosen bit
// R18: Check CRC x^8+x^5+x^4+1 over 56 bits
// R19: Unknown command silences device until reset
// R20: Reset at any point restarts the handshake
`include "id_link_regs.svh"
module id_link_master #(
  parameter int unsigned US_CYC       = `CLK_MHZ,
  parameter int unsigned RST_LOW_CYC  = `T_RST_LOW_US * US_CYC,
  parameter int unsigned RST_HIGH_CYC = `T_RST_HIGH_US * US_CYC,
  parameter logic [7:0]  READ_CMD     = `CMD_READ_ROM
) (
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_rst_n,
  input  wire logic                 i_start,
  input  wire logic                 i_line_in,
  output logic                      o_line_out,
  output logic                      o_line_oe,
  output logic                      o_busy,
  output logic                      o_done,
  output logic                      o_present,
  output logic                      o_crc_ok,
  output id_link_pkg::rom_id_t      o_rom_id
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RESET,
    ST_CMD,
    ST_DATA,
    ST_FINISH
  } state_t;

  // ------------------------------------------------------------
  // Line input synchroniser
  // ------------------------------------------------------------
  logic line_s1_q, line_s2_q;
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      line_s1_q <= 1'b1;
      line_s2_q <= 1'b1;
    end else begin
      line_s1_q <= i_line_in;
      line_s2_q <= line_s1_q;
    end
  end

  id_link_pkg::slot_req_t req_q, req_d;
  id_link_pkg::slot_rsp_t rsp;
  logic                   eng_oe;

  line_slot_engine #(
    .US_CYC       (US_CYC),
    .RST_LOW_CYC  (RST_LOW_CYC),
    .RST_HIGH_CYC (RST_HIGH_CYC)
  ) u_slot (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_req     (req_q),
    .i_line    (line_s2_q),
    .o_line_oe (eng_oe),
    .o_rsp     (rsp)
  );

  // ------------------------------------------------------------
  // Transaction sequencer
  // ------------------------------------------------------------
  state_t      st_q, st_d;
  logic [6:0]  bit_cnt_q, bit_cnt_d;
  logic [63:0] shift_q, shift_d;
  logic [7:0]  crc_q, crc_d;
  logic        wait_q, wait_d;
  logic        present_q, present_d;
  logic        done_q, done_d;
  logic        crc_ok_q, crc_ok_d;
  logic        busy_q, busy_d;
  logic        oe_q;
  logic        crc_fb;

  assign crc_fb = crc_q[0] ^ rsp.bit_val;

  always_comb begin
    st_d      = st_q;
    bit_cnt_d = bit_cnt_q;
    shift_d   = shift_q;
    crc_d     = crc_q;
    wait_d    = wait_q;
    present_d = present_q;
    done_d    = 1'b0;
    crc_ok_d  = crc_ok_q;
    req_d     = '0;
    unique case (st_q)
      ST_IDLE: begin
        if (i_start) begin
          st_d      = ST_RESET; // R7
          req_d     = '{valid: 1'b1, kind: id_link_pkg::SLOT_RESET}; // R20
          wait_d    = 1'b1;
          present_d = 1'b0;
          crc_ok_d  = 1'b0;
        end
      end
      ST_RESET: begin
        if (rsp.done) begin
          present_d = rsp.bit_val; // R8
          bit_cnt_d = '0;
          wait_d    = 1'b0;
          st_d      = rsp.bit_val ? ST_CMD : ST_FINISH;
        end
      end
      ST_CMD: begin
        if (!wait_q) begin
          // Read command only, low bit first; single slave, no search
          req_d.valid = 1'b1;
          req_d.kind  = READ_CMD[bit_cnt_q[2:0]] ?
                        id_link_pkg::SLOT_WRITE1 :
                        id_link_pkg::SLOT_WRITE0; // R2 R11 R17
          wait_d = 1'b1;
        end else if (rsp.done) begin
          wait_d    = 1'b0;
          bit_cnt_d = bit_cnt_q + 7'd1;
          if (bit_cnt_q == 7'(`CMD_BITS - 1)) begin
            bit_cnt_d = '0; // R9
            crc_d     = '0;
            st_d      = ST_DATA;
          end
        end
      end
      ST_DATA: begin
        if (!wait_q) begin
          req_d  = '{valid: 1'b1, kind: id_link_pkg::SLOT_READ}; // R10
          wait_d = 1'b1;
        end else if (rsp.done) begin
          wait_d    = 1'b0;
          shift_d   = {rsp.bit_val, shift_q[63:1]}; // R2
          bit_cnt_d = bit_cnt_q + 7'd1;
          if (bit_cnt_q < 7'd56)
            crc_d = {1'b0, crc_q[7:1]} ^
                    (crc_fb ? `CRC_POLY : 8'h00); // R18
          if (bit_cnt_q == 7'(`ID_BITS - 1))
            st_d = ST_FINISH;
        end
      end
      ST_FINISH: begin
        crc_ok_d = present_q && (shift_q[63:56] == crc_q); // R18
        done_d   = 1'b1;
        st_d     = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
    busy_d = st_d != ST_IDLE;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      st_q      <= ST_IDLE;
      bit_cnt_q <= '0;
      shift_q   <= '0;
      crc_q     <= '0;
      wait_q    <= 1'b0;
      present_q <= 1'b0;
      done_q    <= 1'b0;
      crc_ok_q  <= 1'b0;
      req_q     <= '0;
      oe_q      <= 1'b0;
      busy_q    <= 1'b0;
    end else begin
      st_q      <= st_d;
      bit_cnt_q <= bit_cnt_d;
      shift_q   <= shift_d;
      crc_q     <= crc_d;
      wait_q    <= wait_d;
      present_q <= present_d;
      done_q    <= done_d;
      crc_ok_q  <= crc_ok_d;
      req_q     <= req_d;
      oe_q      <= eng_oe; // R5
      busy_q    <= busy_d;
    end
  end

  // Open drain: data low constant, only enable moves
  assign o_line_out = 1'b0; // R4
  assign o_line_oe  = oe_q;
  assign o_busy     = busy_q;
  assign o_done     = done_q;
  assign o_present  = present_q;
  assign o_crc_ok   = crc_ok_q;
  assign o_rom_id   = {shift_q[7:0], shift_q[55:8], shift_q[63:56]}; // R1

endmodule : id_link_master

// >>> common/id_link_regs.svh
// Timing counts and command codes for the single-line ID link master
`ifndef ID_LINK_REGS_SVH
`define ID_LINK_REGS_SVH

`define CLK_MHZ           250
`define T_RST_LOW_US      480
`define T_RST_HIGH_US     480
`define T_PDH_MAX_US      60
`define T_PDL_MIN_US      60
`define T_SAMPLE_PD_US    70
`define T_SLOT_US         65
`define T_LOW1_US         6
`define T_LOW0_US         60
`define T_RD_SAMPLE_US    12
`define T_REC_US          5
`define CYC(us)           ((us) * `CLK_MHZ)
`define CMD_READ_ROM      8'h33
`define CMD_READ_ROM_OLD  8'h0F
`define CMD_MATCH_ROM     8'h55
`define CMD_SKIP_ROM      8'hCC
`define CMD_SEARCH_ROM    8'hF0
`define ID_BITS           64
`define CMD_BITS          8
`define CRC_POLY          8'h8C

`endif

// >>> common/id_link_pkg.sv
// Types shared by the ID link master
package id_link_pkg;

  typedef enum logic [1:0] {
    SLOT_RESET,
    SLOT_WRITE0,
    SLOT_WRITE1,
    SLOT_READ
  } slot_kind_t;

  typedef struct packed {
    logic       valid;
    slot_kind_t kind;
  } slot_req_t;

  typedef struct packed {
    logic done;
    logic bit_val;
  } slot_rsp_t;

  typedef struct packed {
    logic [7:0]  family;
    logic [47:0] serial;
    logic [7:0]  crc;
  } rom_id_t;

endpackage : id_link_pkg

// >>> src/line_slot_engine.sv
// Timed slot generator for the open-drain line: reset, write and read slots
`include "id_link_regs.svh"
module line_slot_engine #(
  parameter int unsigned US_CYC       = `CLK_MHZ,
  parameter int unsigned RST_LOW_CYC  = `T_RST_LOW_US * US_CYC,
  parameter int unsigned RST_HIGH_CYC = `T_RST_HIGH_US * US_CYC
) (
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_rst_n,
  input  wire id_link_pkg::slot_req_t i_req,
  input  wire logic                  i_line,
  output logic                       o_line_oe,
  output id_link_pkg::slot_rsp_t     o_rsp
);

  localparam int unsigned CW = 20;
  localparam logic [CW-1:0] C_RST_LOW  = CW'(RST_LOW_CYC);
  localparam logic [CW-1:0] C_RST_END  = CW'(RST_LOW_CYC + RST_HIGH_CYC);
  // Cycles per microsecond is a parameter so a fast bench can shrink time
  localparam logic [CW-1:0] C_PD_SMP   =
    CW'(RST_LOW_CYC + `T_SAMPLE_PD_US * US_CYC);
  localparam logic [CW-1:0] C_LOW1     = CW'(`T_LOW1_US * US_CYC);
  localparam logic [CW-1:0] C_LOW0     = CW'(`T_LOW0_US * US_CYC);
  localparam logic [CW-1:0] C_RD_SMP   = CW'(`T_RD_SAMPLE_US * US_CYC);
  localparam logic [CW-1:0] C_SLOT_END =
    CW'((`T_SLOT_US + `T_REC_US) * US_CYC);

  logic                     busy_q, busy_d;
  id_link_pkg::slot_kind_t  kind_q, kind_d;
  logic [CW-1:0]            cnt_q, cnt_d;
  logic                     oe_q, oe_d;
  logic                     bit_q, bit_d;
  logic                     done_q, done_d;

  // ------------------------------------------------------------
  // Slot timing
  // ------------------------------------------------------------
  always_comb begin
    busy_d = busy_q;
    kind_d = kind_q;
    cnt_d  = cnt_q;
    oe_d   = 1'b0;
    bit_d  = bit_q;
    done_d = 1'b0;
    if (!busy_q) begin
      if (i_req.valid) begin
        busy_d = 1'b1;
        kind_d = i_req.kind;
        cnt_d  = '0;
        oe_d   = 1'b1; // R3
      end
    end else begin
      cnt_d = cnt_q + CW'(1);
      unique case (kind_q)
        id_link_pkg::SLOT_RESET:  oe_d = cnt_q < C_RST_LOW - CW'(1); // R6 R15
        id_link_pkg::SLOT_WRITE0: oe_d = cnt_q < C_LOW0 - CW'(1);
        id_link_pkg::SLOT_WRITE1: oe_d = cnt_q < C_LOW1 - CW'(1);
        id_link_pkg::SLOT_READ:   oe_d = cnt_q < C_LOW1 - CW'(1);
      endcase
      // Presence sampled mid-window; read sampled before data valid ends
      if (kind_q == id_link_pkg::SLOT_RESET && cnt_q == C_PD_SMP)
        bit_d = !i_line; // R8
      if (kind_q == id_link_pkg::SLOT_READ && cnt_q == C_RD_SMP)
        bit_d = i_line; // R16
      if ((kind_q == id_link_pkg::SLOT_RESET) ? cnt_q == C_RST_END
                                              : cnt_q == C_SLOT_END) begin
        busy_d = 1'b0;
        done_d = 1'b1; // R14
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      busy_q <= 1'b0;
      kind_q <= id_link_pkg::SLOT_RESET;
      cnt_q  <= '0;
      oe_q   <= 1'b0;
      bit_q  <= 1'b0;
      done_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
      kind_q <= kind_d;
      cnt_q  <= cnt_d;
      oe_q   <= oe_d;
      bit_q  <= bit_d;
      done_q <= done_d;
    end
  end

  assign o_line_oe   = oe_q; // R4
  assign o_rsp.done  = done_q;
  assign o_rsp.bit_val = bit_q;

endmodule : line_slot_engine

// >>> bench/id_link_monitor.sv
// Port checker for the ID link master
`include "id_link_regs.svh"
module id_link_monitor #(
  parameter int unsigned US_CYC      = 250,
  parameter int unsigned RST_LOW_CYC = 120000
) (
  input wire logic                 i_ref_clk,
  input wire logic                 i_rst_n,
  input wire logic                 i_start,
  input wire logic                 i_line_in,
  input wire logic                 o_line_out,
  input wire logic                 o_line_oe,
  input wire logic                 o_busy,
  input wire logic                 o_done,
  input wire logic                 o_present,
  input wire logic                 o_crc_ok,
  input wire id_link_pkg::rom_id_t o_rom_id
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LOW1 = `T_LOW1_US * US_CYC;
  localparam int LOW0 = `T_LOW0_US * US_CYC;
  // Slot spacing floor from the top bit rate
  localparam int MIN_GAP = US_CYC * 10000 / 163;
  logic [17:0] lo_q, lo_d, gap_q, gap_d;
  logic        oe_q;
  default clocking @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);
  // Pull length, and cycles since the last slot start (saturating)
  always_comb begin
    lo_d = o_line_oe ? lo_q + 18'h1 : 18'h0;
    gap_d = gap_q + {17'h0, gap_q != 18'h3FFFF};
    if (o_line_oe && !oe_q) gap_d = 18'h1;
  end
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      lo_q <= 18'h0;
      gap_q <= 18'h3FFFF;
      oe_q <= 1'b0;
    end else begin
      lo_q <= lo_d;
      gap_q <= gap_d;
      oe_q <= o_line_oe;
    end
  end
  a_pull_only: assert property (o_line_oe |-> !o_line_out)
    else $error("line driven high");
  a_idle_release: assert property (!o_busy |-> !o_line_oe)
    else $error("line pulled while idle");
  a_done_pulse: assert property (o_done |=> !o_done)
    else $error("done longer than one cycle");
  a_done_after_busy: assert property ($rose(o_done) |-> $past(o_busy))
    else $error("done without a transaction");
  a_start_reset: assert property (!o_busy && i_start |-> ##[1:3] o_line_oe)
    else $error("start did not open a reset pulse");
  a_low_length: assert property ($fell(o_line_oe) |-> lo_q inside
    {[LOW1:LOW1+2], [LOW0:LOW0+2], [RST_LOW_CYC:RST_LOW_CYC+2]})
    else $error("pull length wrong");
  a_slot_rate: assert property ($rose(o_line_oe) |-> gap_q >= MIN_GAP)
    else $error("slots too close");
  a_result_hold: assert property (!o_busy && !o_done && !i_start |=>
    $stable(o_rom_id) && $stable(o_present) && $stable(o_crc_ok))
    else $error("result changed while idle");
endmodule : id_link_monitor

bind id_link_master id_link_monitor #(
  .US_CYC(US_CYC), .RST_LOW_CYC(RST_LOW_CYC)
) mon_u (
  .i_ref_clk, .i_rst_n, .i_start, .i_line_in, .o_line_out, .o_line_oe,
  .o_busy, .o_done, .o_present, .o_crc_ok, .o_rom_id
);

// >>> bench/id_rom_model.sv
// Behavioural ID word device on the open-drain line
module id_rom_model #(
  parameter int US_NS = 1000
) (
  input  wire logic                 i_line,
  input  wire logic                 i_attached,
  input  wire logic                 i_slow,
  input  wire id_link_pkg::rom_id_t i_rom,
  output logic                      o_pull
);
  timeunit 1ns;
  timeprecision 1ps;
  realtime     t0;
  int          n;
  logic [7:0]  cmd_q;
  logic [63:0] word;
  assign word = {i_rom.crc, i_rom.serial, i_rom.family};
  initial begin
    o_pull = 1'b0;
    n = -1;
    cmd_q = 8'h00;
    forever begin
      @(negedge i_line);
      t0 = $realtime;
      if (n >= 0 && n < 8) begin
        #(30 * US_NS);
        cmd_q[n] = i_line;
      end else if (n >= 8 && n < 72 && cmd_q inside {8'h33, 8'h0F}) begin
        o_pull = !word[n-8];
        #(25 * US_NS);
        o_pull = 1'b0;
      end
      if (n >= 0 && n < 72) n++;
      // Short lows may already be over; waiting would skip a slot
      if (i_line !== 1'b1) @(posedge i_line);
      // Long low restarts, even mid-transfer
      if ($realtime - t0 > 120 * US_NS && i_attached) begin
        #((i_slow ? 58 : 16) * US_NS);
        o_pull = 1'b1;
        #((i_slow ? 200 : 60) * US_NS);
        o_pull = 1'b0;
        n = 0;
      end
    end
  end
endmodule : id_rom_model

// >>> bench/tb.sv
// Self-checking bench for the ID link master
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic                 pres;
    logic                 full;
    logic                 crc_ok;
    id_link_pkg::rom_id_t rom;
  } exp_t;
  logic i_ref_clk, i_rst_n, i_start, attached, slow, pull;
  logic o_line_out, o_line_oe, o_busy, o_done, o_present, o_crc_ok;
  wire  line;
  id_link_pkg::rom_id_t rom_in, o_rom_id;
  exp_t e, x, expq[$];
  int   failures, tests_run, w;

  assign line = !(o_line_oe || pull);

  // Four cycles per microsecond keeps the run short; model scaled to match
  id_link_master #(.US_CYC(4)) dut_u (
    .i_ref_clk, .i_rst_n, .i_start, .i_line_in(line), .o_line_out,
    .o_line_oe, .o_busy, .o_done, .o_present, .o_crc_ok, .o_rom_id
  );
  id_rom_model #(.US_NS(16)) dev_u (
    .i_line(line), .i_attached(attached), .i_slow(slow), .i_rom(rom_in),
    .o_pull(pull)
  );

  function automatic logic [7:0] crc8(input logic [55:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 56; i++) c = (c >> 1) ^ ((c[0] ^ d[i]) ? 8'h8C : 8'h00);
    return c;
  endfunction : crc8

  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      failures++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic stop_test();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test

  initial begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end

  always @(posedge i_ref_clk) begin
    if (o_done === 1'b1) begin
      if (expq.size() == 0) check(1'b0, "extra completion");
      else begin
        e = expq.pop_front();
        check(o_present === e.pres, "presence flag");
        if (e.full) check(o_rom_id === e.rom, "id word");
        if (e.full) check(o_crc_ok === e.crc_ok, "crc flag");
      end
    end
  end

  // Device present, absent, then slow with a corrupt check byte
  initial begin
    i_rst_n = 1'b0;
    i_start = 1'b0;
    attached = 1'b0;
    slow = 1'b0;
    rom_in = '0;
    failures = 0;
    tests_run = 0;
    void'($urandom(54));
    repeat (20) @(negedge i_ref_clk);
    i_rst_n = 1'b1;
    repeat (2) @(negedge i_ref_clk);
    for (int k = 0; k < 3; k++) begin
      attached = (k != 1);
      slow = (k == 2);
      rom_in.family = 8'($urandom);
      rom_in.serial = 48'({$urandom, $urandom});
      rom_in.crc = crc8({rom_in.serial, rom_in.family}) ^ {7'h00, slow};
      x = '{attached, attached, !slow, rom_in};
      expq.push_back(x);
      i_start = 1'b1;
      @(negedge i_ref_clk);
      i_start = 1'b0;
      repeat (100) @(negedge i_ref_clk);
      // Start while busy must be ignored
      i_start = 1'b1;
      @(negedge i_ref_clk);
      i_start = 1'b0;
      for (w = 0; w < 40000 && o_done !== 1'b1; w++) @(negedge i_ref_clk);
      check(o_done === 1'b1, "no completion");
      @(negedge i_ref_clk);
    end
    repeat (10) @(negedge i_ref_clk);
    stop_test();
  end

  initial begin
    #400000;
    failures++;
    stop_test();
  end
endmodule : tb
